// ===== design/org_pkg.sv
// package: register map, fields, reset values and timing for the output routing/gain bank
package org_pkg;
    localparam logic [7:0] ORG_OFS_MIXER_ROUTING = 8'h23;
    localparam logic [7:0] ORG_OFS_HP_VOLUME = 8'h24;
    localparam logic [7:0] ORG_OFS_RSVD_HP_VOLUME = 8'h25;
    localparam logic [7:0] ORG_OFS_SPK_VOLUME = 8'h26;
    localparam logic [7:0] ORG_OFS_RSVD_SPK_VOLUME = 8'h27;
    localparam logic [7:0] ORG_OFS_HP_DRIVER = 8'h28;
    localparam logic [7:0] ORG_OFS_RSVD_HP_DRIVER = 8'h29;
    localparam logic [7:0] ORG_OFS_SPK_DRIVER = 8'h2A;
    localparam logic [7:0] ORG_OFS_RSVD_SPK_DRIVER = 8'h2B;

    // field positions
    localparam int ORG_POS_DAC_ROUTE = 6;
    localparam int ORG_POS_FIRST_IN_ROUTE = 5;
    localparam int ORG_POS_SECOND_IN_ROUTE = 4;
    localparam int ORG_POS_VOL_ROUTE = 7;
    localparam int ORG_POS_HP_GAIN = 3;
    localparam int ORG_POS_MUTE_OFF = 2;
    localparam int ORG_POS_HP_HIZ = 1;
    localparam int ORG_POS_SPK_GAIN = 3;
    localparam int ORG_POS_APPLIED = 0;

    // reset values
    localparam logic [7:0] ORG_RST_MIXER_ROUTING = 8'h00;
    localparam logic [7:0] ORG_RST_VOLUME = 8'h7F;
    localparam logic [7:0] ORG_RST_RSVD_VOLUME = 8'h7F;
    localparam logic [7:0] ORG_RST_HP_DRIVER = 8'h02;
    localparam logic [7:0] ORG_RST_SPK_DRIVER = 8'h00;
    localparam logic [7:0] ORG_RST_RSVD_UNDEF = 8'h00;

    // writable bit masks of the mixer and driver registers
    localparam logic [7:0] ORG_MASK_MIXER = 8'hF0;
    localparam logic [7:0] ORG_MASK_HP_DRIVER = 8'h7E;
    localparam logic [7:0] ORG_MASK_SPK_DRIVER = 8'h1C;

    localparam logic [3:0] ORG_HP_GAIN_MAX = 4'h9;
    localparam logic [1:0] ORG_DAC_ROUTE_NONE = 2'h0;
    localparam logic [1:0] ORG_DAC_ROUTE_MIXER = 2'h1;
    localparam logic [1:0] ORG_DAC_ROUTE_HP = 2'h2;

    // settling time of a gain or mute change
    localparam int ORG_CLK_HZ = 10_000_000;
    localparam int ORG_SETTLE_US = 100;
    localparam int ORG_SETTLE_CYCLES = (ORG_SETTLE_US * (ORG_CLK_HZ / 1_000_000) > 0)
        ? ORG_SETTLE_US * (ORG_CLK_HZ / 1_000_000) : 1;

    typedef enum logic [1:0] {
        ORG_ST_APPLIED = 2'b00,
        ORG_ST_SETTLING = 2'b01
    } org_settle_st_t;
endpackage : org_pkg

// ===== design/org_settle.sv
// settle tracker: gain-applied flag per output path
`timescale 1ns/100ps
`default_nettype none
module org_settle
    import org_pkg::*;
#(
    parameter int SETTLE_CYCLES = ORG_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic change,
    output logic applied
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    org_settle_st_t state;
    logic [CW-1:0] count;
    wire count_done = (count == CW'(SETTLE_CYCLES - 1));

    // a new write restarts the wait, so the flag rises only after the last change
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= ORG_ST_APPLIED;
            count <= '0;
        end else begin
            case (state)
                ORG_ST_APPLIED: begin
                    if (change) begin
                        state <= ORG_ST_SETTLING;
                        count <= '0;
                    end
                end
                ORG_ST_SETTLING: begin
                    if (change) begin
                        count <= '0;
                    end else if (count_done) begin
                        state <= ORG_ST_APPLIED;
                    end else begin
                        count <= count + CW'(1);
                    end
                end
                default: begin
                    state <= ORG_ST_APPLIED;
                    count <= '0;
                end
            endcase
        end
    end

    assign applied = (state == ORG_ST_APPLIED);
endmodule : org_settle
`default_nettype wire

// ===== design/org_regs.sv
// output routing and gain register bank with driver control outputs
`timescale 1ns/100ps
`default_nettype none
module org_regs
    import org_pkg::*;
#(
    parameter int SETTLE_CYCLES = ORG_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    // register port of the control bus front end
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // path controls toward the analog section
    output logic dac_to_mixer,
    output logic dac_to_headphone_output,
    output logic analog_input_first_to_mixer,
    output logic analog_input_second_to_mixer,
    output logic volume_to_headphone_output,
    output logic [6:0] headphone_output_atten,
    output logic volume_to_speaker,
    output logic [6:0] speaker_atten,
    output logic [3:0] headphone_output_gain,
    output logic headphone_output_mute,
    output logic headphone_output_hiz_pd,
    output logic headphone_output_applied,
    output logic [1:0] speaker_stage_gain,
    output logic speaker_mute,
    output logic speaker_applied
);
    logic [7:0] mixer_routing;
    logic [7:0] hp_volume;
    logic [7:0] rsvd_hp_volume;
    logic [7:0] spk_volume;
    logic [7:0] rsvd_spk_volume;
    logic [7:0] hp_driver;
    logic [7:0] rsvd_hp_driver;
    logic [7:0] spk_driver;
    logic [7:0] rsvd_spk_driver;

    function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : wr_hit

    wire wr_mixer = reg_write && wr_hit(reg_addr, ORG_OFS_MIXER_ROUTING);
    wire wr_hp_vol = reg_write && wr_hit(reg_addr, ORG_OFS_HP_VOLUME);
    wire wr_rsvd_hp_vol = reg_write && wr_hit(reg_addr, ORG_OFS_RSVD_HP_VOLUME);
    wire wr_spk_vol = reg_write && wr_hit(reg_addr, ORG_OFS_SPK_VOLUME);
    wire wr_rsvd_spk_vol = reg_write && wr_hit(reg_addr, ORG_OFS_RSVD_SPK_VOLUME);
    wire wr_hp_drv = reg_write && wr_hit(reg_addr, ORG_OFS_HP_DRIVER);
    wire wr_rsvd_hp_drv = reg_write && wr_hit(reg_addr, ORG_OFS_RSVD_HP_DRIVER);
    wire wr_spk_drv = reg_write && wr_hit(reg_addr, ORG_OFS_SPK_DRIVER);
    wire wr_rsvd_spk_drv = reg_write && wr_hit(reg_addr, ORG_OFS_RSVD_SPK_DRIVER);

    // reserved gain codes are clamped rather than stored, so the stage never sees them
    wire [3:0] wr_hp_gain = reg_wdata[ORG_POS_HP_GAIN +: 4];
    wire [3:0] safe_hp_gain = (wr_hp_gain > ORG_HP_GAIN_MAX) ? ORG_HP_GAIN_MAX : wr_hp_gain;
    wire [7:0] next_hp_driver = {1'b0, safe_hp_gain,
        reg_wdata[ORG_POS_MUTE_OFF], reg_wdata[ORG_POS_HP_HIZ], 1'b0};

    always_ff @(posedge clock) begin
        if (srst) begin
            mixer_routing <= ORG_RST_MIXER_ROUTING;
            hp_volume <= ORG_RST_VOLUME;
            spk_volume <= ORG_RST_VOLUME;
            rsvd_hp_volume <= ORG_RST_RSVD_VOLUME;
            rsvd_spk_volume <= ORG_RST_RSVD_VOLUME;
            hp_driver <= ORG_RST_HP_DRIVER;
            spk_driver <= ORG_RST_SPK_DRIVER;
            rsvd_hp_driver <= ORG_RST_RSVD_UNDEF;
            rsvd_spk_driver <= ORG_RST_RSVD_UNDEF;
        end else begin
            if (wr_mixer) begin
                mixer_routing <= reg_wdata & ORG_MASK_MIXER;
            end
            if (wr_hp_vol) begin
                hp_volume <= reg_wdata;
            end
            if (wr_spk_vol) begin
                spk_volume <= reg_wdata;
            end
            if (wr_rsvd_hp_vol) begin
                rsvd_hp_volume <= reg_wdata;
            end
            if (wr_rsvd_spk_vol) begin
                rsvd_spk_volume <= reg_wdata;
            end
            if (wr_hp_drv) begin
                hp_driver <= next_hp_driver & ORG_MASK_HP_DRIVER;
            end
            if (wr_spk_drv) begin
                spk_driver <= reg_wdata & ORG_MASK_SPK_DRIVER;
            end
            // held only so a stray write reads back; the analog side ignores them
            if (wr_rsvd_hp_drv) begin
                rsvd_hp_driver <= reg_wdata;
            end
            if (wr_rsvd_spk_drv) begin
                rsvd_spk_driver <= reg_wdata;
            end
        end
    end

    // any gain, attenuation or mute write restarts the settling of that path
    wire hp_change = wr_hp_vol || wr_hp_drv;
    wire spk_change = wr_spk_vol || wr_spk_drv;

    org_settle #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_hp_settle (
        .clock(clock),
        .srst(srst),
        .change(hp_change),
        .applied(headphone_output_applied)
    );

    org_settle #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_spk_settle (
        .clock(clock),
        .srst(srst),
        .change(spk_change),
        .applied(speaker_applied)
    );

    // dac route decode; the reserved code routes nowhere
    wire [1:0] dac_route = mixer_routing[ORG_POS_DAC_ROUTE +: 2];
    assign dac_to_mixer = (dac_route == ORG_DAC_ROUTE_MIXER);
    assign dac_to_headphone_output = (dac_route == ORG_DAC_ROUTE_HP);
    assign analog_input_first_to_mixer = mixer_routing[ORG_POS_FIRST_IN_ROUTE];
    assign analog_input_second_to_mixer = mixer_routing[ORG_POS_SECOND_IN_ROUTE];
    assign volume_to_headphone_output = hp_volume[ORG_POS_VOL_ROUTE];
    assign headphone_output_atten = hp_volume[6:0];
    assign volume_to_speaker = spk_volume[ORG_POS_VOL_ROUTE];
    assign speaker_atten = spk_volume[6:0];
    assign headphone_output_gain = hp_driver[ORG_POS_HP_GAIN +: 4];
    assign headphone_output_mute = ~hp_driver[ORG_POS_MUTE_OFF];
    assign headphone_output_hiz_pd = hp_driver[ORG_POS_HP_HIZ];
    assign speaker_stage_gain = spk_driver[ORG_POS_SPK_GAIN +: 2];
    assign speaker_mute = ~spk_driver[ORG_POS_MUTE_OFF];

    // read mux; status bits replace bit 0 of the driver registers
    wire [7:0] rd_hp_drv = {hp_driver[7:1], headphone_output_applied};
    wire [7:0] rd_spk_drv = {spk_driver[7:1], speaker_applied};
    assign reg_rdata =
        (reg_addr == ORG_OFS_MIXER_ROUTING) ? mixer_routing :
        (reg_addr == ORG_OFS_HP_VOLUME) ? hp_volume :
        (reg_addr == ORG_OFS_RSVD_HP_VOLUME) ? rsvd_hp_volume :
        (reg_addr == ORG_OFS_SPK_VOLUME) ? spk_volume :
        (reg_addr == ORG_OFS_RSVD_SPK_VOLUME) ? rsvd_spk_volume :
        (reg_addr == ORG_OFS_HP_DRIVER) ? rd_hp_drv :
        (reg_addr == ORG_OFS_RSVD_HP_DRIVER) ? rsvd_hp_driver :
        (reg_addr == ORG_OFS_SPK_DRIVER) ? rd_spk_drv :
        (reg_addr == ORG_OFS_RSVD_SPK_DRIVER) ? rsvd_spk_driver :
        8'h00;
endmodule : org_regs
`default_nettype wire

// ===== dv/org_regs_chk.sv
// checker: register-to-output relations of the routing and gain bank
`timescale 1ns/100ps
`default_nettype none
module org_regs_chk
    import org_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic dac_to_mixer,
    input wire logic dac_to_headphone_output,
    input wire logic analog_input_first_to_mixer,
    input wire logic [3:0] headphone_output_gain,
    input wire logic headphone_output_mute,
    input wire logic headphone_output_applied,
    input wire logic [1:0] speaker_stage_gain,
    input wire logic speaker_applied
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    wire logic wr_mix = reg_write && reg_addr == ORG_OFS_MIXER_ROUTING;
    wire logic wr_hp = reg_write && reg_addr == ORG_OFS_HP_DRIVER;
    wire logic wr_spk = reg_write && reg_addr == ORG_OFS_SPK_DRIVER;
    wire logic wr_hpv = reg_write && reg_addr == ORG_OFS_HP_VOLUME;
    wire logic wr_spv = reg_write && reg_addr == ORG_OFS_SPK_VOLUME;
    a_route_mixer: assert property (wr_mix |=> dac_to_mixer == ($past(reg_wdata[7:6]) == 2'h1))
        else $error("mixer route differs from code");
    a_route_direct: assert property (wr_mix |=>
        dac_to_headphone_output == ($past(reg_wdata[7:6]) == 2'h2))
        else $error("direct route differs from code");
    a_first_input: assert property (wr_mix |=> analog_input_first_to_mixer == $past(reg_wdata[5]))
        else $error("first input route wrong");
    a_hp_mute: assert property (wr_hp |=> headphone_output_mute == !$past(reg_wdata[2]))
        else $error("headphone mute wrong");
    a_hp_gain_range: assert property (headphone_output_gain <= 4'h9)
        else $error("headphone gain above nine");
    a_spk_gain: assert property (wr_spk |=> speaker_stage_gain == $past(reg_wdata[4:3]))
        else $error("speaker stage gain wrong");
    a_hp_flag_clear: assert property ((wr_hp || wr_hpv) |=> !headphone_output_applied [*2])
        else $error("headphone applied flag not cleared");
    a_spk_flag_clear: assert property ((wr_spk || wr_spv) |=> !speaker_applied [*2])
        else $error("speaker applied flag not cleared");
    a_hp_status_read: assert property (reg_addr == ORG_OFS_HP_DRIVER |->
        reg_rdata[0] == headphone_output_applied) else $error("headphone status read wrong");
    a_hp_rise_quiet: assert property ($rose(headphone_output_applied) |-> !$past(wr_hp || wr_hpv))
        else $error("headphone applied rose right after a write");
    a_spk_rise_quiet: assert property ($rose(speaker_applied) |-> !$past(wr_spk || wr_spv))
        else $error("speaker applied rose right after a write");
    c_hp_settled: cover property ($rose(headphone_output_applied));
    c_spk_settled: cover property ($rose(speaker_applied));
    c_direct_route: cover property (wr_mix && reg_wdata[7:6] == 2'h2);
endmodule : org_regs_chk
bind org_regs org_regs_chk u_chk (.clock, .srst, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
    .dac_to_mixer, .dac_to_headphone_output, .analog_input_first_to_mixer, .headphone_output_gain,
    .headphone_output_mute, .headphone_output_applied, .speaker_stage_gain, .speaker_applied);
`default_nettype wire

// ===== dv/org_regs_tb.sv
// testbench: register writes, read-back and output checks of the routing and gain bank
`timescale 1ns/100ps
`default_nettype none
module org_regs_tb;
    import org_pkg::*;
    localparam int SC = 4;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_write = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, r;
    logic [6:0] headphone_output_atten, speaker_atten;
    logic dac_to_mixer, dac_to_headphone_output, analog_input_first_to_mixer;
    logic analog_input_second_to_mixer, volume_to_headphone_output, volume_to_speaker;
    logic headphone_output_mute, headphone_output_hiz_pd, headphone_output_applied;
    logic speaker_mute, speaker_applied;
    logic [3:0] headphone_output_gain;
    logic [1:0] speaker_stage_gain;
    logic [7:0] m [256];
    logic [15:0] q [$];
    logic [15:0] ent;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    org_regs #(.SETTLE_CYCLES(SC)) DUT (.clock, .srst, .reg_addr, .reg_write, .reg_wdata,
        .reg_rdata, .dac_to_mixer, .dac_to_headphone_output, .analog_input_first_to_mixer,
        .analog_input_second_to_mixer, .volume_to_headphone_output, .headphone_output_atten,
        .volume_to_speaker, .speaker_atten, .headphone_output_gain, .headphone_output_mute,
        .headphone_output_hiz_pd, .headphone_output_applied, .speaker_stage_gain, .speaker_mute,
        .speaker_applied);
    initial begin
        forever #50 clock = ~clock;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // what the analog section should see for a given register value
    function automatic logic [7:0] exp_out(input logic [7:0] a, input logic [7:0] v);
        case (a)
            8'h23: exp_out = {4'h0, v[7:6] == 2'h2, v[7:6] == 2'h1, v[5:4]};
            8'h24, 8'h26: exp_out = v;
            8'h28: exp_out = {1'b0, v[6:3], ~v[2], v[1:0]};
            8'h2A: exp_out = {4'h0, v[4:3], ~v[2], v[0]};
            default: exp_out = 8'h00;
        endcase
    endfunction : exp_out
    function automatic logic [7:0] obs_out(input logic [7:0] a);
        case (a)
            8'h23: obs_out = {4'h0, dac_to_headphone_output, dac_to_mixer,
                analog_input_first_to_mixer, analog_input_second_to_mixer};
            8'h24: obs_out = {volume_to_headphone_output, headphone_output_atten};
            8'h26: obs_out = {volume_to_speaker, speaker_atten};
            8'h28: obs_out = {1'b0, headphone_output_gain, headphone_output_mute,
                headphone_output_hiz_pd, headphone_output_applied};
            8'h2A: obs_out = {4'h0, speaker_stage_gain, speaker_mute, speaker_applied};
            default: obs_out = 8'h00;
        endcase
    endfunction : obs_out
    // only mapped registers are ever written
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
        if (a == 8'h23) m[a] = d & 8'hF0;
        else m[a] = (a == 8'h28) ? {1'b0, d[6:1], 1'b0} : (a == 8'h2A) ? {3'h0, d[4:2], 2'h0} : d;
        if (a == 8'h24 || a == 8'h28) m[8'h28][0] = 1'b0;
        if (a == 8'h26 || a == 8'h2A) m[8'h2A][0] = 1'b0;
    endtask : wr
    // the watcher compares at the next rising edge
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        reg_addr = a;
        q.push_back({a, m[a]});
    endtask : rd
    task automatic settle();
        repeat (SC + 2) @(negedge clock);
        m[8'h28][0] = 1'b1;
        m[8'h2A][0] = 1'b1;
    endtask : settle
    task automatic reset_check();
        @(negedge clock);
        srst = 1'b1;
        repeat (8) @(negedge clock);
        srst = 1'b0;
        foreach (m[i]) m[i] = 8'h00;
        for (int i = 8'h24; i < 8'h28; i++) m[i] = 8'h7F;
        m[8'h28] = 8'h03;
        m[8'h2A] = 8'h01;
        for (int i = 8'h22; i < 8'h2D; i++) rd(8'(i));
    endtask : reset_check
    task automatic complete_run();
        if (q.size() != 0) begin
            mismatches++;
            $display("MISMATCH queue exp 0 got %0d", q.size());
        end
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    always @(posedge clock) begin
        if (q.size() > 0) begin
            ent = q.pop_front();
            comparisons += 2;
            if (reg_rdata !== ent[7:0]) begin
                mismatches++;
                $display("MISMATCH rdata %h exp %h got %h", ent[15:8], ent[7:0], reg_rdata);
            end
            if (obs_out(ent[15:8]) !== exp_out(ent[15:8], ent[7:0])) begin
                mismatches++;
                $display("MISMATCH outputs %h exp %h got %h", ent[15:8],
                    exp_out(ent[15:8], ent[7:0]), obs_out(ent[15:8]));
            end
        end
    end
    // generous ceiling; the sequence needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        r = 8'h33;
        reset_check();
        for (int c = 0; c < 8; c++) begin
            r = lfsr(r);
            wr(8'h23, {2'(c), r[5:4], 4'h0});
            rd(8'h23);
        end
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            wr(8'h24, r);
            rd(8'h24);
            wr(8'h26, ~r);
            rd(8'h26);
        end
        for (int g = 0; g < 10; g++) begin
            r = lfsr(r);
            wr(8'h28, {1'b0, 4'(g), r[1:0], 1'b0});
            rd(8'h28);
        end
        for (int g = 0; g < 4; g++) begin
            r = lfsr(r);
            wr(8'h2A, {3'h0, 2'(g), r[0], 2'h0});
            rd(8'h2A);
        end
        settle();
        wr(8'h23, 8'h40);
        rd(8'h28);
        rd(8'h2A);
        wr(8'h24, 8'h05);
        rd(8'h28);
        wr(8'h26, 8'h80);
        rd(8'h2A);
        settle();
        rd(8'h28);
        rd(8'h2A);
        reset_check();
        rd(8'h2B);
        // let the watcher take the last note before the verdict
        repeat (2) @(negedge clock);
        complete_run();
    end
endmodule : org_regs_tb
`default_nettype wire
